// file: design/ssr_pkg.sv
// *****************************************************************
// Shared constants of the synchronous slave receiver
// *****************************************************************
package ssr_pkg;

    // Register index width of the plain register port
    localparam int ADDR_W = 4;

    // *****************************************************************
    // Register offsets
    // *****************************************************************
    localparam logic [3:0] OFS_RCV_STAT = 4'h0;
    localparam logic [3:0] OFS_RCV_BUF = 4'h1;
    localparam logic [3:0] OFS_TX_STAT = 4'h2;
    localparam logic [3:0] OFS_RATE_POL = 4'h3;
    localparam logic [3:0] OFS_DIV_HI = 4'h4;
    localparam logic [3:0] OFS_DIV_LO = 4'h5;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h6;
    localparam logic [3:0] OFS_IRQ_CLR = 4'h7;
    localparam logic [3:0] OFS_IRQ_EN = 4'h8;

    // *****************************************************************
    // Field positions
    // *****************************************************************
    // receive_status_control
    localparam int RS_PORT_EN = 7;
    localparam int RS_NINTH_EN = 6;
    localparam int RS_SINGLE = 5;
    localparam int RS_CONT = 4;
    localparam int RS_FRAME_ERR = 2;
    localparam int RS_OVR_ERR = 1;
    localparam int RS_NINTH = 0;
    // transmit_status_control
    localparam int TS_CLK_SRC = 7;
    localparam int TS_SYNC = 4;
    // rate_and_polarity_control
    localparam int RP_IDLE = 6;
    localparam int RP_DATA_POL = 5;
    localparam int RP_CLK_POL = 4;
    // Interrupt status, clear and enable share this layout
    localparam int IRQ_WORD = 0;
    localparam int IRQ_OVR = 1;
    localparam int IRQ_FULL = 2;
    localparam int IRQ_W = 2;

    // *****************************************************************
    // Reset values and word lengths
    // *****************************************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_IRQ = 2'h0;
    localparam logic [3:0] WORD_LEN_SHORT = 4'h8;
    localparam logic [3:0] WORD_LEN_LONG = 4'h9;

    // Shifter states
    typedef enum logic [1:0]
    {
        SSR_ST_OFF = 2'b01,
        SSR_ST_SHIFT = 2'b10
    } ssr_state_t;

endpackage

// file: design/ssr_shift_if.sv
`timescale 1ns/1ps
// *****************************************************************
// Link between register core and shifter
// *****************************************************************
interface ssr_shift_if;
    logic enable;       // Reception allowed
    logic clk_invert;   // Invert clock pin
    logic data_invert;  // Invert data pin
    logic nine_bits;    // Nine-bit words
    logic word_stb;     // One-cycle pulse: word complete
    logic [8:0] word;   // Received word, valid with word_stb
    logic busy;         // Part of a word shifted in

    modport core (output enable, clk_invert, data_invert, nine_bits,
                  input word_stb, word, busy);
    modport shifter (input enable, clk_invert, data_invert, nine_bits,
                     output word_stb, word, busy);
endinterface

// file: design/ssr_shifter.sv
`timescale 1ns/1ps
// *****************************************************************
// Pin sampling and receive shift register
// *****************************************************************
module ssr_shifter
    import ssr_pkg::*;
#(
    parameter int SYNC_STAGES = 2
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic serial_clock_pin,
    input wire logic serial_data_pin,
    ssr_shift_if.shifter sh
);

    // Fewer than two stages would expose metastability
    if (SYNC_STAGES < 2)
    begin : g_chk
        $error("SYNC_STAGES must be at least 2");
    end

    // *****************************************************************
    // Synchronisers
    // *****************************************************************
    logic [SYNC_STAGES-1:0] ck_sync_r; // Clock pin chain
    logic [SYNC_STAGES-1:0] dt_sync_r; // Data pin chain
    logic ck_prev_r;                   // Last polarised clock level
    logic ck_pol;
    logic dt_pol;
    logic act_edge;

    // Only the last stage of each chain is read by logic
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ck_sync_r <= '0;
            dt_sync_r <= '0;
        end
        else
        begin
            ck_sync_r <= {ck_sync_r[SYNC_STAGES-2:0], serial_clock_pin};
            dt_sync_r <= {dt_sync_r[SYNC_STAGES-2:0], serial_data_pin};
        end
    end

    assign ck_pol = ck_sync_r[SYNC_STAGES-1] ^ sh.clk_invert;
    assign dt_pol = dt_sync_r[SYNC_STAGES-1] ^ sh.data_invert;

    // Previous level for edge finding
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            ck_prev_r <= 1'b0;
        else
            ck_prev_r <= ck_pol;
    end

    // Rising edge of the polarised external clock
    assign act_edge = ck_pol & ~ck_prev_r;

    // *****************************************************************
    // Shift register
    // *****************************************************************
    ssr_state_t state_r;
    logic [3:0] count_r;  // Bits taken so far
    logic [8:0] shift_r;  // Receive shift register, LSB first
    logic [3:0] len;
    logic stb_r;
    logic [8:0] word_r;

    assign len = sh.nine_bits ? WORD_LEN_LONG : WORD_LEN_SHORT;

    // One sample per active edge; disabling drops a partial word
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= SSR_ST_OFF;
            count_r <= 4'h0;
            shift_r <= 9'h000;
            stb_r <= 1'b0;
            word_r <= 9'h000;
        end
        else
        begin
            stb_r <= 1'b0;
            unique case (state_r)
                SSR_ST_OFF:
                begin
                    count_r <= 4'h0;
                    if (sh.enable)
                        state_r <= SSR_ST_SHIFT;
                end
                SSR_ST_SHIFT:
                begin
                    if (!sh.enable)
                    begin
                        state_r <= SSR_ST_OFF;
                        count_r <= 4'h0;
                    end
                    else if (act_edge)
                    begin
                        shift_r <= {dt_pol, shift_r[8:1]};
                        if (count_r == len - 4'h1)
                        begin
                            count_r <= 4'h0;
                            stb_r <= 1'b1;
                            // Eight-bit words sit one place higher
                            word_r <= sh.nine_bits ? {dt_pol, shift_r[8:1]}
                                                   : {1'b0, dt_pol, shift_r[8:2]};
                        end
                        else
                            count_r <= count_r + 4'h1;
                    end
                end
            endcase
        end
    end

    assign sh.word_stb = stb_r;
    assign sh.word = word_r;
    assign sh.busy = (count_r != 4'h0);

    // *****************************************************************
    // Checks
    // *****************************************************************
    a_count_bound: assert property (@(posedge ref_clk) disable iff (!rst_b)
        count_r < len) else $error("bit count past word length");

    a_strobe_single: assert property (@(posedge ref_clk) disable iff (!rst_b)
        stb_r |=> !stb_r) else $error("word strobe longer than a cycle");

endmodule

// file: design/ssr_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Single-receive and low-power state change nothing in reception
// - Words still accepted during low power
// - Finished word moves into receive buffer
// - Enabled receive interrupt wakes sleeping chip
// - Slave mode takes shift clock from outside
// - Clock polarity select inverts clock pin
// - Data polarity select inverts data pin
// - Ninth-bit enable gives nine-bit words
// - No words accepted without continuous enable
// - Completion flag set; interrupt only if enabled
// - Status holds ninth bit and errors
// - Low eight bits read from buffer
// - Clearing continuous enable clears error state
module ssr_top
    import ssr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic serial_clock_pin,
    input wire logic serial_data_pin,
    input wire logic low_power,
    output logic irq,
    output logic wake_req
);

    // *****************************************************************
    // Decoding
    // *****************************************************************
    logic wr_rcv_stat; // Write to receive_status_control
    logic wr_tx_stat;  // Write to transmit_status_control
    logic wr_rate_pol; // Write to rate_and_polarity_control
    logic wr_div_hi;   // Write to rate_divisor_high
    logic wr_div_lo;   // Write to rate_divisor_low
    logic wr_irq_clr;  // Write to interrupt clear
    logic wr_irq_en;   // Write to interrupt enable
    logic rd_buf;      // Read of receive buffer

    assign wr_rcv_stat = reg_wr && (reg_addr == OFS_RCV_STAT);
    assign wr_tx_stat = reg_wr && (reg_addr == OFS_TX_STAT);
    assign wr_rate_pol = reg_wr && (reg_addr == OFS_RATE_POL);
    assign wr_div_hi = reg_wr && (reg_addr == OFS_DIV_HI);
    assign wr_div_lo = reg_wr && (reg_addr == OFS_DIV_LO);
    assign wr_irq_clr = reg_wr && (reg_addr == OFS_IRQ_CLR);
    assign wr_irq_en = reg_wr && (reg_addr == OFS_IRQ_EN);
    assign rd_buf = reg_rd && (reg_addr == OFS_RCV_BUF);

    // *****************************************************************
    // Control registers
    // *****************************************************************
    logic port_enable_r;               // Serial port on
    logic ninth_bit_receive_enable_r;  // Nine-bit words
    logic single_receive_enable_r;     // Stored but has no effect here
    logic continuous_receive_enable_r; // Reception on
    logic clock_source_select_r;       // Set means internal clock
    logic sync_mode_r;                 // Synchronous operation
    logic data_polarity_select_r;      // Invert data pin
    logic clock_polarity_select_r;     // Invert clock pin
    logic [7:0] div_hi_r;              // Kept for software only
    logic [7:0] div_lo_r;              // Kept for software only

    // receive_status_control writable fields
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            port_enable_r <= RST_BYTE[RS_PORT_EN];
            ninth_bit_receive_enable_r <= RST_BYTE[RS_NINTH_EN];
            single_receive_enable_r <= RST_BYTE[RS_SINGLE];
            continuous_receive_enable_r <= RST_BYTE[RS_CONT];
        end
        else if (wr_rcv_stat)
        begin
            port_enable_r <= reg_wdata[RS_PORT_EN];
            ninth_bit_receive_enable_r <= reg_wdata[RS_NINTH_EN];
            single_receive_enable_r <= reg_wdata[RS_SINGLE];
            continuous_receive_enable_r <= reg_wdata[RS_CONT];
        end
    end

    // transmit_status_control mode fields
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            clock_source_select_r <= RST_BYTE[TS_CLK_SRC];
            sync_mode_r <= RST_BYTE[TS_SYNC];
        end
        else if (wr_tx_stat)
        begin
            clock_source_select_r <= reg_wdata[TS_CLK_SRC];
            sync_mode_r <= reg_wdata[TS_SYNC];
        end
    end

    // Pin polarity fields
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            data_polarity_select_r <= RST_BYTE[RP_DATA_POL];
            clock_polarity_select_r <= RST_BYTE[RP_CLK_POL];
        end
        else if (wr_rate_pol)
        begin
            data_polarity_select_r <= reg_wdata[RP_DATA_POL];
            clock_polarity_select_r <= reg_wdata[RP_CLK_POL];
        end
    end

    // Rate divisor: no internal clock in slave mode, so only stored
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_hi_r <= RST_BYTE;
            div_lo_r <= RST_BYTE;
        end
        else
        begin
            if (wr_div_hi)
                div_hi_r <= reg_wdata;
            if (wr_div_lo)
                div_lo_r <= reg_wdata;
        end
    end

    // *****************************************************************
    // Shifter
    // *****************************************************************
    ssr_shift_if sh_if();
    logic overrun_error_flag_r; // Word arrived with buffer full

    // Slave reception needs sync mode, port on and external clock;
    // low_power deliberately plays no part, so sleep keeps receiving
    assign sh_if.enable = port_enable_r && sync_mode_r && !clock_source_select_r
                          && continuous_receive_enable_r
                          && !overrun_error_flag_r;
    assign sh_if.clk_invert = clock_polarity_select_r;
    assign sh_if.data_invert = data_polarity_select_r;
    assign sh_if.nine_bits = ninth_bit_receive_enable_r;

    ssr_shifter #(
        .SYNC_STAGES(2)
    ) u_shifter (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .serial_clock_pin(serial_clock_pin),
        .serial_data_pin(serial_data_pin),
        .sh(sh_if.shifter)
    );

    // *****************************************************************
    // Receive buffer and errors
    // *****************************************************************
    logic [7:0] buf_r;               // Receive buffer
    logic received_ninth_bit_r;      // Ninth bit of buffered word
    logic receive_complete_flag_r;   // Buffer holds an unread word
    logic accept;                    // Finished word while enabled
    logic load;                      // Word goes into the buffer
    logic lost;                      // Word dropped, buffer still full

    // A read in the same cycle frees the slot, so no overrun then
    assign accept = sh_if.word_stb && continuous_receive_enable_r;
    assign load = accept && (!receive_complete_flag_r || rd_buf);
    assign lost = accept && receive_complete_flag_r && !rd_buf;

    // Move shift register into buffer on completion
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            buf_r <= RST_BYTE;
            received_ninth_bit_r <= 1'b0;
        end
        else if (load)
        begin
            buf_r <= sh_if.word[7:0];
            // Ninth bit only meaningful in nine-bit mode
            received_ninth_bit_r <= ninth_bit_receive_enable_r
                                    && sh_if.word[8];
        end
    end

    // Completion flag: set on load wins over the read that clears it
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            receive_complete_flag_r <= 1'b0;
        else if (load)
            receive_complete_flag_r <= 1'b1;
        else if (rd_buf)
            receive_complete_flag_r <= 1'b0;
    end

    // Error state lives only while continuous enable is set
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            overrun_error_flag_r <= 1'b0;
        else if (!continuous_receive_enable_r)
            overrun_error_flag_r <= 1'b0;
        else if (lost)
            overrun_error_flag_r <= 1'b1;
    end

    // *****************************************************************
    // Interrupts
    // *****************************************************************
    logic [IRQ_W-1:0] irq_stat_r; // Sticky event bits
    logic [IRQ_W-1:0] irq_en_r;   // Event enables
    logic [IRQ_W-1:0] irq_set;
    logic irq_r;
    logic wake_r;
    logic pending;

    assign irq_set = {lost, load};
    assign pending = |(irq_stat_r & irq_en_r);

    // Set beats a clear written in the same cycle
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            irq_stat_r <= RST_IRQ;
        else if (wr_irq_clr)
            irq_stat_r <= (irq_stat_r & ~reg_wdata[IRQ_W-1:0]) | irq_set;
        else
            irq_stat_r <= irq_stat_r | irq_set;
    end

    // Enable register, bit 0 is receive_interrupt_enable
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            irq_en_r <= RST_IRQ;
        else if (wr_irq_en)
            irq_en_r <= reg_wdata[IRQ_W-1:0];
    end

    // Level outputs; wake only matters while in low power
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_r <= 1'b0;
            wake_r <= 1'b0;
        end
        else
        begin
            irq_r <= pending;
            wake_r <= pending && low_power;
        end
    end

    assign irq = irq_r;
    assign wake_req = wake_r;

    // *****************************************************************
    // Read path
    // *****************************************************************
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // Unmapped and write-only offsets read as zero
    always_comb
    begin
        rdata_nxt = 8'h00;
        unique case (reg_addr)
            OFS_RCV_STAT:
            begin
                rdata_nxt[RS_PORT_EN] = port_enable_r;
                rdata_nxt[RS_NINTH_EN] = ninth_bit_receive_enable_r;
                rdata_nxt[RS_SINGLE] = single_receive_enable_r;
                rdata_nxt[RS_CONT] = continuous_receive_enable_r;
                // No stop bit in synchronous words, so framing stays 0
                rdata_nxt[RS_FRAME_ERR] = 1'b0;
                rdata_nxt[RS_OVR_ERR] = overrun_error_flag_r;
                rdata_nxt[RS_NINTH] = received_ninth_bit_r;
            end
            OFS_RCV_BUF:
                rdata_nxt = buf_r;
            OFS_TX_STAT:
            begin
                rdata_nxt[TS_CLK_SRC] = clock_source_select_r;
                rdata_nxt[TS_SYNC] = sync_mode_r;
            end
            OFS_RATE_POL:
            begin
                rdata_nxt[RP_IDLE] = !sh_if.busy;
                rdata_nxt[RP_DATA_POL] = data_polarity_select_r;
                rdata_nxt[RP_CLK_POL] = clock_polarity_select_r;
            end
            OFS_DIV_HI:
                rdata_nxt = div_hi_r;
            OFS_DIV_LO:
                rdata_nxt = div_lo_r;
            OFS_IRQ_STAT:
            begin
                rdata_nxt[IRQ_W-1:0] = irq_stat_r;
                rdata_nxt[IRQ_FULL] = receive_complete_flag_r;
            end
            OFS_IRQ_EN:
                rdata_nxt[IRQ_W-1:0] = irq_en_r;
            default:
                rdata_nxt = 8'h00;
        endcase
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata_r <= 8'h00;
        else if (reg_rd)
            rdata_r <= rdata_nxt;
        else
            rdata_r <= 8'h00;
    end

    assign reg_rdata = rdata_r;

    // *****************************************************************
    // Checks
    // *****************************************************************
    a_buffer_load: assert property (@(posedge ref_clk) disable iff (!rst_b)
        load |=> receive_complete_flag_r && (buf_r == $past(sh_if.word[7:0])))
        else $error("finished word not in buffer");

    a_ninth_bit: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (load && ninth_bit_receive_enable_r) |=>
        received_ninth_bit_r == $past(sh_if.word[8]))
        else $error("ninth bit not kept");

    a_no_enable_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !continuous_receive_enable_r |=> $stable(buf_r)
        && (!irq_stat_r[IRQ_WORD] || $past(irq_stat_r[IRQ_WORD])))
        else $error("word taken while reception off");

    a_error_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !continuous_receive_enable_r |=> !overrun_error_flag_r)
        else $error("error state kept with reception off");

    a_overrun_keep: assert property (@(posedge ref_clk) disable iff (!rst_b)
        lost |=> overrun_error_flag_r && $stable(buf_r))
        else $error("overrun not flagged or buffer overwritten");

    a_flag_event: assert property (@(posedge ref_clk) disable iff (!rst_b)
        load |=> irq_stat_r[IRQ_WORD] ##1 (irq == irq_en_r[IRQ_WORD]))
        else $error("completion event or interrupt wrong");

    a_irq_masked: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !pending |=> !irq)
        else $error("interrupt without enabled event");

    a_wake_sleep: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (pending && low_power) |=> wake_req && irq)
        else $error("no wake from low power");

    a_slave_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clock_source_select_r |=> !sh_if.word_stb [*2])
        else $error("word taken with internal clock selected");

endmodule

// file: test/ssr_master_model.sv
`timescale 1ns/1ps
// ****
// Far-side synchronous master
// ****
module ssr_master_model
(
    output logic sclk,
    output logic sdat
);
    // Clock stands still outside frames
    initial {sclk, sdat} = 2'b00;
    // Idle level set before reception is armed, so no stray edge
    task automatic park(input logic cp);
        sclk = cp;
    endtask
    // Bit 0 first, 64 ns per bit; cp is the idle level
    task automatic send(input logic [8:0] w, input int n, input logic cp, input logic dp);
        for (int i = 0; i < n; i++)
        begin
            sdat = w[i] ^ dp;
            #32 sclk = ~cp;
            #32 sclk = cp;
        end
        // Released line shows the inverse, never a stale bit
        sdat = ~sdat;
    endtask
endmodule

// file: test/sync_slave_serial_receiver_bench.sv
`timescale 1ns/1ps
// ****
// Receiver bench
// ****
module sync_slave_serial_receiver_bench;
    import ssr_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic low_power = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic sclk, sdat, irq, wake_req;
    int err_count, n_checks;
    // Rows: data pol, clock pol, nine-bit, word
    logic [11:0] rows [4] = '{12'h0A5, 12'h73C, 12'h8F0, 12'hF01};
    ssr_top uut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .serial_clock_pin(sclk), .serial_data_pin(sdat), .low_power(low_power),
        .irq(irq), .wake_req(wake_req));
    ssr_master_model m (.sclk(sclk), .sdat(sdat));
    // 200 MHz
    initial forever #2.5 ref_clk = ~ref_clk;
    task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s exp %h got %h", n, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk("rdata", reg_rdata, e);
    endtask
    // Disarm, set polarity, park the clock, then arm
    task automatic cfg(input logic [11:0] r, input logic [7:0] c);
        wr(4'h0, 8'h80);
        wr(4'h3, {2'b00, r[11], r[10], 4'h0});
        m.park(r[10]);
        wr(4'h0, c | {1'b0, r[9], 6'h00});
    endtask
    task automatic word(input logic [11:0] r);
        m.send(r[8:0], r[9] ? 9 : 8, r[10], r[11]);
        repeat (12) @(posedge ref_clk);
        #1;
    endtask
    task automatic end_sim();
        if (err_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(4'h0, 8'h00);
        rd(4'h3, 8'h40);
        rd(4'hF, 8'h00);
        wr(4'h2, 8'h10);
        foreach (rows[i])
        begin
            cfg(rows[i], 8'h90);
            word(rows[i]);
            rd(4'h6, 8'h05);
            chk("irq", {7'h00, irq}, 8'h00);
            rd(4'h0, 8'h90 | {1'b0, rows[i][9], 5'h00, rows[i][9] & rows[i][8]});
            rd(4'h1, rows[i][7:0]);
            rd(4'h6, 8'h01);
            wr(4'h7, 8'h03);
        end
        // Internal clock source, then reception off: word ignored
        wr(4'h2, 8'h90);
        cfg(12'h0A5, 8'h90);
        word(12'h0A5);
        rd(4'h6, 8'h00);
        wr(4'h2, 8'h10);
        cfg(12'h0A5, 8'h80);
        word(12'h0A5);
        rd(4'h6, 8'h00);
        // Armed first, then low power, single-receive bit set
        wr(4'h8, 8'h01);
        cfg(12'h05A, 8'hB0);
        low_power <= 1'b1;
        word(12'h05A);
        chk("irq", {7'h00, irq}, 8'h01);
        chk("wake", {7'h00, wake_req}, 8'h01);
        rd(4'h1, 8'h5A);
        rd(4'h0, 8'hB0);
        wr(4'h8, 8'h00);
        repeat (2) @(posedge ref_clk);
        #1 chk("irq", {7'h00, irq}, 8'h00);
        wr(4'h8, 8'h01);
        wr(4'h7, 8'h01);
        // Overrun, refused word, then clear by disarming
        low_power <= 1'b0;
        cfg(12'h011, 8'h90);
        word(12'h011);
        word(12'h022);
        rd(4'h6, 8'h07);
        rd(4'h0, 8'h92);
        word(12'h033);
        rd(4'h1, 8'h11);
        wr(4'h0, 8'h80);
        rd(4'h0, 8'h80);
        // Mid-run reset: sticky bits, mode and interrupt back to zero
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(4'h6, 8'h00);
        rd(4'h2, 8'h00);
        chk("irq", {7'h00, irq}, 8'h00);
        end_sim();
    end
    // Hang guard, well past the expected run
    initial
    begin
        #300000;
        err_count++;
        end_sim();
    end
endmodule
